// ### swbm_pkg.sv
// package of constants for the single-wire bus master event block
// Operation
// - set reset-complete flag when a generated bus reset finishes
// - set operation-complete flag at end of a write or read transaction; read phase when combined
// - set no-responder flag when no presence seen after bus reset
// - set stuck-bus flag when line held low by another party
// - set transfer-engine-done flag when a one is written to bit 0 of the engine-done register
// - clear register deasserts only the selected flags
// - only enabled flags drive the interrupt output
// - one enable bit per event source, written as a mask
// - raw and masked views of the flags are both readable
// - bit count 1 to 32; exactly that many bits are shifted
// - reset, write, read selects combine; reset comes first
// - write phase runs before read phase
// - bus active flag high during reset, write or read
// - received bits default to one unless a slave pulls low
package swbm_pkg;
    localparam logic [7:0] SWBM_CTRL_OFFSET = 8'h00;
    localparam logic [7:0] SWBM_WDATA_OFFSET = 8'h04;
    localparam logic [7:0] SWBM_RDATA_OFFSET = 8'h08;
    localparam logic [7:0] SWBM_BUS_STATUS_OFFSET = 8'h0C;
    localparam logic [7:0] SWBM_RAW_STATUS_OFFSET = 8'h10;
    localparam logic [7:0] SWBM_MASKED_STATUS_OFFSET = 8'h14;
    localparam logic [7:0] SWBM_ENABLE_OFFSET = 8'h18;
    localparam logic [7:0] SWBM_CLEAR_OFFSET = 8'h1C;
    localparam logic [7:0] SWBM_DMA_DONE_OFFSET = 8'h20;
    localparam int SWBM_CTRL_RESET_BIT = 0;
    localparam int SWBM_CTRL_WRITE_BIT = 1;
    localparam int SWBM_CTRL_READ_BIT = 2;
    localparam int SWBM_CTRL_COUNT_LSB = 8;
    localparam int SWBM_BUS_ACTIVE_BIT = 0;
    localparam int SWBM_BUS_NO_RESP_BIT = 1;
    localparam int SWBM_BUS_STUCK_BIT = 2;
    localparam int SWBM_EV_RESET = 0;
    localparam int SWBM_EV_OP = 1;
    localparam int SWBM_EV_NO_RESP = 2;
    localparam int SWBM_EV_STUCK = 3;
    localparam int SWBM_EV_DMA = 4;
    localparam int SWBM_EVENTS = 5;
    localparam logic [4:0] SWBM_ENABLE_RESET = 5'h00;
    localparam logic [31:0] SWBM_RDATA_RESET = 32'hFFFFFFFF;
    localparam int SWBM_CLK_NS = 40;
    localparam int SWBM_RESET_LOW_NS = 480;
    localparam int SWBM_PRESENCE_NS = 70;
    localparam int SWBM_RESET_SLOT_NS = 960;
    localparam int SWBM_SLOT_NS = 120;
    localparam int SWBM_ONE_LOW_NS = 8;
    localparam int SWBM_ZERO_LOW_NS = 64;
    localparam int SWBM_SAMPLE_NS = 80;
    localparam int SWBM_STUCK_NS = 960;
    localparam int SWBM_RESET_LOW_CYC = (SWBM_RESET_LOW_NS + SWBM_CLK_NS - 1) / SWBM_CLK_NS;
    localparam int SWBM_PRESENCE_CYC = SWBM_RESET_LOW_CYC + SWBM_PRESENCE_NS / SWBM_CLK_NS;
    localparam int SWBM_RESET_SLOT_CYC = (SWBM_RESET_SLOT_NS + SWBM_CLK_NS - 1) / SWBM_CLK_NS;
    localparam int SWBM_SLOT_CYC = (SWBM_SLOT_NS + SWBM_CLK_NS - 1) / SWBM_CLK_NS;
    localparam int SWBM_ONE_LOW_CYC = (SWBM_ONE_LOW_NS + SWBM_CLK_NS - 1) / SWBM_CLK_NS;
    localparam int SWBM_ZERO_LOW_CYC = (SWBM_ZERO_LOW_NS + SWBM_CLK_NS - 1) / SWBM_CLK_NS;
    localparam int SWBM_SAMPLE_CYC = (SWBM_SAMPLE_NS + SWBM_CLK_NS - 1) / SWBM_CLK_NS;
    localparam int SWBM_STUCK_CYC = (SWBM_STUCK_NS + SWBM_CLK_NS - 1) / SWBM_CLK_NS;
endpackage

// ### swbm_event_if.sv
// interface carrying event pulses and flag state between core and event register
`timescale 1ns/1ps
interface swbm_event_if;
    logic [4:0] set;
    logic [4:0] clear;
    logic clear_valid;
    logic [4:0] enable;
    logic [4:0] raw;
    logic [4:0] masked;
    logic irq;
    modport core (output set, output clear, output clear_valid, output enable,
        input raw, input masked, input irq);
    modport regs (input set, input clear, input clear_valid, input enable,
        output raw, output masked, output irq);
endinterface

// ### swbm_event_reg.sv
// sticky event flags with enable gating and interrupt output
`timescale 1ns/1ps
module swbm_event_reg
    import swbm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    swbm_event_if.regs ev
);
    typedef struct packed {
        logic [4:0] raw;
        logic [4:0] masked;
        logic irq;
    } swbm_evreg_type;
    swbm_evreg_type state;
    swbm_evreg_type next_state;

    always_comb begin
        next_state = state;
        if (ev.clear_valid) begin
            next_state.raw = state.raw & ~ev.clear;
        end
        next_state.raw = next_state.raw | ev.set;
        next_state.masked = next_state.raw & ev.enable;
        next_state.irq = |next_state.masked;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign ev.raw = state.raw;
    assign ev.masked = state.masked;
    assign ev.irq = state.irq;

    property p_set_sticks;
        @(posedge aclk) disable iff (!aresetn)
        |ev.set |=> ((state.raw & $past(ev.set)) == $past(ev.set));
    endproperty
    a_set_sticks: assert property (p_set_sticks) else $error("event set lost");

    property p_hold;
        @(posedge aclk) disable iff (!aresetn)
        (!ev.clear_valid && ev.set == 5'h00) |=> (state.raw == $past(state.raw));
    endproperty
    a_hold: assert property (p_hold) else $error("flag changed without cause");

    property p_clear;
        @(posedge aclk) disable iff (!aresetn)
        (ev.clear_valid && ((ev.clear & ev.set) == 5'h00)) |=>
            ((state.raw & $past(ev.clear)) == 5'h00);
    endproperty
    a_clear: assert property (p_clear) else $error("selected flag not cleared");

    property p_irq;
        @(posedge aclk) disable iff (!aresetn)
        state.irq == |(state.raw & $past(ev.enable));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not gated by enable");
endmodule

// ### swbm_top.sv
// single-wire bus master transaction engine with axi4-lite registers
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module swbm_top
    import swbm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic line_in,
    output logic line_out,
    output logic line_oe,
    output logic irq
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_RST_LOW, ST_RST_WAIT, ST_BIT, ST_DONE
    } swbm_phase_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic arready;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [4:0] enable;
        logic [31:0] wshift;
        logic [31:0] rshift;
        logic [31:0] rd_result;
        logic [5:0] count;
        logic [5:0] bit_idx;
        logic do_write;
        logic do_read;
        logic in_read;
        logic presence;
        logic no_resp;
        logic stuck;
        logic [9:0] low_cnt;
        logic [9:0] timer;
        swbm_phase_type phase;
        logic line_oe;
        logic irq;
    } swbm_state_type;

    swbm_state_type state;
    swbm_state_type next_state;
    swbm_event_if ev ();

    function automatic logic [31:0] reg_read(input logic [7:0] addr, input swbm_state_type s,
                                             input logic [4:0] raw, input logic [4:0] masked);
        reg_read = 32'h00000000;
        unique case (addr)
            SWBM_RDATA_OFFSET: reg_read = s.rd_result;
            SWBM_BUS_STATUS_OFFSET: begin
                reg_read[SWBM_BUS_ACTIVE_BIT] = (s.phase != ST_IDLE);
                reg_read[SWBM_BUS_NO_RESP_BIT] = s.no_resp;
                reg_read[SWBM_BUS_STUCK_BIT] = s.stuck;
            end
            SWBM_RAW_STATUS_OFFSET: reg_read[4:0] = raw;
            SWBM_MASKED_STATUS_OFFSET: reg_read[4:0] = masked;
            SWBM_ENABLE_OFFSET: reg_read[4:0] = s.enable;
            default: reg_read = 32'h00000000;
        endcase
    endfunction

    function automatic logic addr_ok(input logic [7:0] addr, input logic is_write);
        unique case (addr)
            SWBM_CTRL_OFFSET, SWBM_WDATA_OFFSET, SWBM_ENABLE_OFFSET,
            SWBM_CLEAR_OFFSET, SWBM_DMA_DONE_OFFSET: addr_ok = is_write;
            SWBM_RDATA_OFFSET, SWBM_BUS_STATUS_OFFSET, SWBM_RAW_STATUS_OFFSET,
            SWBM_MASKED_STATUS_OFFSET: addr_ok = !is_write || 1'b0;
            default: addr_ok = 1'b0;
        endcase
        if (addr == SWBM_ENABLE_OFFSET) begin
            addr_ok = 1'b1;
        end
    endfunction

    logic wr_fire;
    logic [4:0] ev_set;
    logic [4:0] ev_clear;
    logic ev_clear_valid;

    always_comb begin
        next_state = state;
        ev_set = 5'h00;
        ev_clear = 5'h00;
        ev_clear_valid = 1'b0;
        wr_fire = 1'b0;
        // write address and data taken in either order
        if (state.awready && s_axi_awvalid) begin
            next_state.awready = 1'b0;
            next_state.aw_got = 1'b1;
            next_state.awaddr = s_axi_awaddr;
        end
        if (state.wready && s_axi_wvalid) begin
            next_state.wready = 1'b0;
            next_state.w_got = 1'b1;
            next_state.wdata = s_axi_wdata;
            next_state.wstrb = s_axi_wstrb;
        end
        if (state.aw_got && state.w_got && !state.bvalid) begin
            wr_fire = 1'b1;
            next_state.aw_got = 1'b0;
            next_state.w_got = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = addr_ok(state.awaddr, 1'b1) ? 2'b00 : 2'b10;
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
            next_state.awready = 1'b1;
            next_state.wready = 1'b1;
        end
        if (wr_fire && state.wstrb == 4'hF) begin
            unique case (state.awaddr)
                SWBM_ENABLE_OFFSET: next_state.enable = state.wdata[4:0];
                SWBM_CLEAR_OFFSET: begin
                    ev_clear = state.wdata[4:0];
                    ev_clear_valid = 1'b1;
                end
                SWBM_WDATA_OFFSET: next_state.wshift = state.wdata;
                SWBM_DMA_DONE_OFFSET: ev_set[SWBM_EV_DMA] = state.wdata[0];
                SWBM_CTRL_OFFSET: begin
                    if (state.phase == ST_IDLE) begin
                        // count 1..32, zero taken as 32
                        next_state.count = (state.wdata[SWBM_CTRL_COUNT_LSB +: 6] == 6'h00 ||
                            state.wdata[SWBM_CTRL_COUNT_LSB +: 6] > 6'd32) ? 6'd32 :
                            state.wdata[SWBM_CTRL_COUNT_LSB +: 6];
                        next_state.do_write = state.wdata[SWBM_CTRL_WRITE_BIT];
                        next_state.do_read = state.wdata[SWBM_CTRL_READ_BIT];
                        next_state.bit_idx = 6'h00;
                        next_state.timer = 10'h000;
                        next_state.rshift = SWBM_RDATA_RESET;
                        if (state.wdata[SWBM_CTRL_RESET_BIT]) begin
                            next_state.phase = ST_RST_LOW;
                            next_state.presence = 1'b0;
                        end else if (state.wdata[SWBM_CTRL_WRITE_BIT] ||
                                     state.wdata[SWBM_CTRL_READ_BIT]) begin
                            next_state.phase = ST_BIT;
                            next_state.in_read = !state.wdata[SWBM_CTRL_WRITE_BIT];
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        // read channel
        if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end
        if (state.arready && s_axi_arvalid) begin
            next_state.rvalid = 1'b1;
            next_state.rdata = reg_read(s_axi_araddr, state, ev.raw, ev.masked);
            next_state.rresp = addr_ok(s_axi_araddr, 1'b0) ? 2'b00 : 2'b10;
        end
        next_state.arready = !next_state.rvalid;
        // stuck-low watch while master releases the line
        if (!state.line_oe && !line_in) begin
            if (state.low_cnt != 10'(SWBM_STUCK_CYC)) begin
                next_state.low_cnt = state.low_cnt + 10'h001;
            end
            if (state.low_cnt == 10'(SWBM_STUCK_CYC - 1)) begin
                ev_set[SWBM_EV_STUCK] = 1'b1;
                next_state.stuck = 1'b1;
            end
        end else begin
            next_state.low_cnt = 10'h000;
            next_state.stuck = 1'b0;
        end
        next_state.timer = (state.phase == ST_IDLE) ? 10'h000 : state.timer + 10'h001;
        unique case (state.phase)
            ST_IDLE: begin
                next_state.line_oe = 1'b0;
            end
            ST_RST_LOW: begin
                next_state.line_oe = 1'b1;
                if (state.timer == 10'(SWBM_RESET_LOW_CYC - 1)) begin
                    next_state.line_oe = 1'b0;
                    next_state.phase = ST_RST_WAIT;
                end
            end
            ST_RST_WAIT: begin
                if (state.timer >= 10'(SWBM_RESET_LOW_CYC + 1) && !line_in) begin
                    next_state.presence = 1'b1;
                end
                if (state.timer == 10'(SWBM_RESET_SLOT_CYC - 1)) begin
                    next_state.timer = 10'h000;
                    ev_set[SWBM_EV_RESET] = 1'b1;
                    ev_set[SWBM_EV_NO_RESP] = !state.presence;
                    next_state.no_resp = !state.presence;
                    next_state.in_read = !state.do_write;
                    next_state.phase = (state.do_write || state.do_read) ? ST_BIT : ST_IDLE;
                end
            end
            ST_BIT: begin
                // a zero only when a slave pulls low at sample
                if (state.in_read) begin
                    next_state.line_oe = (state.timer < 10'(SWBM_ONE_LOW_CYC));
                    if (state.timer == 10'(SWBM_SAMPLE_CYC) && !line_in) begin
                        next_state.rshift[state.bit_idx[4:0]] = 1'b0;
                    end
                end else begin
                    next_state.line_oe = state.wshift[state.bit_idx[4:0]] ?
                        (state.timer < 10'(SWBM_ONE_LOW_CYC)) :
                        (state.timer < 10'(SWBM_ZERO_LOW_CYC));
                end
                if (state.timer == 10'(SWBM_SLOT_CYC - 1)) begin
                    next_state.timer = 10'h000;
                    next_state.line_oe = 1'b0;
                    next_state.bit_idx = state.bit_idx + 6'h01;
                    if (state.bit_idx == state.count - 6'h01) begin
                        next_state.bit_idx = 6'h00;
                        if (!state.in_read && state.do_read) begin
                            next_state.in_read = 1'b1;
                        end else begin
                            next_state.phase = ST_DONE;
                        end
                    end
                end
            end
            ST_DONE: begin
                ev_set[SWBM_EV_OP] = 1'b1;
                if (state.do_read) begin
                    next_state.rd_result = state.rshift;
                end
                next_state.phase = ST_IDLE;
            end
        endcase
        next_state.irq = ev.irq;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
            state.awready <= 1'b1;
            state.wready <= 1'b1;
            state.arready <= 1'b1;
            state.enable <= SWBM_ENABLE_RESET;
            state.rd_result <= SWBM_RDATA_RESET;
            state.phase <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign ev.set = ev_set;
    assign ev.clear = ev_clear;
    assign ev.clear_valid = ev_clear_valid;
    assign ev.enable = state.enable;

    swbm_event_reg u_event_reg (
        .aclk(aclk),
        .aresetn(aresetn),
        .ev(ev)
    );

    assign s_axi_awready = state.awready;
    assign s_axi_wready = state.wready;
    assign s_axi_bvalid = state.bvalid;
    assign s_axi_bresp = state.bresp;
    assign s_axi_arready = state.arready;
    assign s_axi_rvalid = state.rvalid;
    assign s_axi_rdata = state.rdata;
    assign s_axi_rresp = state.rresp;
    assign line_out = 1'b0;
    assign line_oe = state.line_oe;
    assign irq = state.irq;

    property p_busy;
        @(posedge aclk) disable iff (!aresetn)
        (state.line_oe) |-> (state.phase != ST_IDLE);
    endproperty
    a_busy: assert property (p_busy) else $error("line driven while idle");

    property p_reset_done;
        @(posedge aclk) disable iff (!aresetn)
        (state.phase == ST_RST_WAIT && $past(state.phase) == ST_RST_LOW) |->
            ##[1:30] ev_set[SWBM_EV_RESET];
    endproperty
    a_reset_done: assert property (p_reset_done) else $error("reset done missing");

    property p_op_done;
        @(posedge aclk) disable iff (!aresetn)
        ev_set[SWBM_EV_OP] |-> (state.phase == ST_DONE && (!state.do_read || state.in_read));
    endproperty
    a_op_done: assert property (p_op_done) else $error("op done before read phase");

    property p_count;
        @(posedge aclk) disable iff (!aresetn)
        (state.phase == ST_BIT) |-> (state.bit_idx < state.count);
    endproperty
    a_count: assert property (p_count) else $error("bit index beyond count");

    property p_no_resp;
        @(posedge aclk) disable iff (!aresetn)
        ev_set[SWBM_EV_NO_RESP] |-> (ev_set[SWBM_EV_RESET] && !state.presence);
    endproperty
    a_no_resp: assert property (p_no_resp) else $error("no responder outside reset end");

    property p_stuck;
        @(posedge aclk) disable iff (!aresetn)
        ev_set[SWBM_EV_STUCK] |-> (!state.line_oe && !line_in && $past(!line_in));
    endproperty
    a_stuck: assert property (p_stuck) else $error("stuck flag while line free");

    c_reset_txn: cover property (@(posedge aclk) state.phase == ST_RST_WAIT);
    c_combined: cover property (@(posedge aclk) state.phase == ST_BIT && state.in_read &&
        state.do_write);
    c_irq: cover property (@(posedge aclk) irq);
endmodule

// ### swbm_slave_model.sv
// behavioural slave on the shared single-wire line
`timescale 1ns/1ps
module swbm_slave_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic line_oe,
    input wire logic present,
    input wire logic stuck,
    input wire logic restart,
    input wire logic [31:0] rd_pat,
    input wire logic [5:0] rd_skip,
    output logic line_in,
    output logic [6:0] slots,
    output logic [31:0] wr_bits
);
    logic prev_oe;
    logic hold;
    logic [5:0] len;
    logic [2:0] pres_cnt;
    logic zero_bit;
    assign zero_bit = (slots >= 7'(rd_skip)) && !rd_pat[5'(slots - 7'(rd_skip))];
    assign line_in = !(line_oe || stuck || hold || (pres_cnt != 3'h0 && pres_cnt != 3'h5));
    always_ff @(posedge aclk) begin
        if (!aresetn || restart) begin
            prev_oe <= 1'b0;
            hold <= 1'b0;
            len <= 6'h00;
            pres_cnt <= 3'h0;
            slots <= 7'h00;
            wr_bits <= 32'h00000000;
        end else begin
            prev_oe <= line_oe;
            // zero held past the master's release
            hold <= line_oe && zero_bit;
            len <= line_oe ? len + 6'h01 : 6'h00;
            if (pres_cnt != 3'h0) begin
                pres_cnt <= pres_cnt - 3'h1;
            end
            if (prev_oe && !line_oe) begin
                if (len >= 6'h08) begin
                    if (present) begin
                        pres_cnt <= 3'h5;
                    end
                end else begin
                    if (slots < 7'h20) begin
                        wr_bits[slots[4:0]] <= (len == 6'h01);
                    end
                    slots <= slots + 7'h01;
                end
            end
        end
    end
endmodule

// ### single_wire_bus_master_events_bench.sv
// self-checking bench for the single-wire bus master
`timescale 1ns/1ps
module single_wire_bus_master_events_bench
    import swbm_pkg::*;
;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, wr_bits, rd_pat, d, wd, rp, m;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic line_in, line_out, line_oe, irq, present, stuck, restart;
    logic [6:0] slots;
    logic [5:0] rd_skip, cnt;
    logic [2:0] op;
    int miscompares = 0;
    int n_compared = 0;
    swbm_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .line_in(line_in),
        .line_out(line_out), .line_oe(line_oe), .irq(irq));
    swbm_slave_model slave (.aclk(aclk), .aresetn(aresetn), .line_oe(line_oe), .present(present),
        .stuck(stuck), .restart(restart), .rd_pat(rd_pat), .rd_skip(rd_skip), .line_in(line_in),
        .slots(slots), .wr_bits(wr_bits));
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    task automatic complete_run;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tmo;
        miscompares++;
        complete_run();
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        resp = s_axi_bresp;
        if (n == 100) tmo();
    endtask
    task automatic axr(input logic [7:0] a);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        resp = s_axi_rresp;
        if (n == 100) tmo();
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        axr(a);
        chk(nm, d, exp);
    endtask
    function automatic logic [31:0] exp_raw(input logic [2:0] o, input logic p);
        exp_raw = 32'h0;
        exp_raw[SWBM_EV_RESET] = o[SWBM_CTRL_RESET_BIT];
        exp_raw[SWBM_EV_NO_RESP] = o[SWBM_CTRL_RESET_BIT] && !p;
        exp_raw[SWBM_EV_OP] = o[SWBM_CTRL_WRITE_BIT] || o[SWBM_CTRL_READ_BIT];
    endfunction
    task automatic trx;
        int n;
        rd_pat <= op[SWBM_CTRL_READ_BIT] ? rp : 32'hFFFFFFFF;
        rd_skip <= op[SWBM_CTRL_WRITE_BIT] ? cnt : 6'h00;
        restart <= 1'b1;
        @(posedge aclk);
        restart <= 1'b0;
        axw(SWBM_CLEAR_OFFSET, 32'h0000001F);
        axw(SWBM_WDATA_OFFSET, wd);
        axw(SWBM_CTRL_OFFSET, {18'h0, cnt, 5'h0, op});
        axr(SWBM_BUS_STATUS_OFFSET);
        chk("bus active", 32'(d[SWBM_BUS_ACTIVE_BIT]), 32'h1);
        // poll until the line is idle
        for (n = 0; n < 300 && d[SWBM_BUS_ACTIVE_BIT] !== 1'b0; n++) axr(SWBM_BUS_STATUS_OFFSET);
        if (n == 300) tmo();
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, stuck, restart, rd_skip} = '0;
        s_axi_wstrb = 4'hF;
        present = 1'b1;
        rd_pat = 32'hFFFFFFFF;
        void'($urandom(32'h570a));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc("rdata reset", SWBM_RDATA_OFFSET, SWBM_RDATA_RESET);
        rc("enable reset", SWBM_ENABLE_OFFSET, 32'(SWBM_ENABLE_RESET));
        rc("raw reset", SWBM_RAW_STATUS_OFFSET, 32'h0);
        axw(SWBM_ENABLE_OFFSET, 32'h0000001F);
        chk("write okay", 32'(resp), 32'h0);
        rc("enable", SWBM_ENABLE_OFFSET, 32'h1F);
        {op, cnt, wd, rp} = {3'h1, 6'h08, 64'h0};
        trx();
        rc("reset done", SWBM_RAW_STATUS_OFFSET, exp_raw(op, 1'b1));
        chk("irq on", 32'(irq), 32'h1);
        present <= 1'b0;
        trx();
        rc("no responder", SWBM_RAW_STATUS_OFFSET, exp_raw(op, 1'b0));
        rc("no responder bus", SWBM_BUS_STATUS_OFFSET, 32'h1 << SWBM_BUS_NO_RESP_BIT);
        axw(SWBM_CLEAR_OFFSET, 32'h1 << SWBM_EV_NO_RESP);
        rc("partial clear", SWBM_RAW_STATUS_OFFSET, 32'h1);
        axw(SWBM_ENABLE_OFFSET, 32'h00000002);
        rc("masked off", SWBM_MASKED_STATUS_OFFSET, 32'h0);
        chk("irq masked", 32'(irq), 32'h0);
        axw(SWBM_ENABLE_OFFSET, 32'h00000001);
        rc("masked on", SWBM_MASKED_STATUS_OFFSET, 32'h1);
        chk("irq enabled", 32'(irq), 32'h1);
        s_axi_wstrb <= 4'h1;
        axw(SWBM_ENABLE_OFFSET, 32'h00000000);
        s_axi_wstrb <= 4'hF;
        rc("partial strobe", SWBM_ENABLE_OFFSET, 32'h1);
        for (int i = 0; i < 12; i++) begin
            cnt = (i == 0) ? 6'd1 : (i == 1) ? 6'd32 : 6'($urandom_range(1, 32));
            op = (i < 3) ? 3'h6 : 3'($urandom_range(2, 7));
            present <= 1'($urandom_range(0, 1));
            wd = $urandom();
            rp = (i == 2) ? 32'hFFFFFFFF : $urandom();
            m = (cnt == 6'd32) ? 32'hFFFFFFFF : (32'h1 << cnt) - 32'h1;
            trx();
            chk("slots", 32'(slots), (op[1] ? 32'(cnt) : 0) + (op[2] ? 32'(cnt) : 0));
            if (op[1]) chk("written", wr_bits & m, wd & m);
            axr(SWBM_RDATA_OFFSET);
            if (op[2]) chk("read", d & m, rp & m);
            rc("raw op", SWBM_RAW_STATUS_OFFSET, exp_raw(op, present));
        end
        axw(SWBM_CLEAR_OFFSET, 32'h0000001F);
        stuck <= 1'b1;
        repeat (40) @(posedge aclk);
        stuck <= 1'b0;
        repeat (4) @(posedge aclk);
        rc("stuck", SWBM_RAW_STATUS_OFFSET, 32'h1 << SWBM_EV_STUCK);
        axw(SWBM_CLEAR_OFFSET, 32'h0000001F);
        axw(SWBM_DMA_DONE_OFFSET, 32'h00000001);
        rc("engine done", SWBM_RAW_STATUS_OFFSET, 32'h1 << SWBM_EV_DMA);
        axw(SWBM_CLEAR_OFFSET, 32'h1 << SWBM_EV_DMA);
        rc("cleared", SWBM_RAW_STATUS_OFFSET, 32'h0);
        axr(8'h40);
        chk("unmapped", 32'(resp), 32'h2);
        axw(SWBM_RAW_STATUS_OFFSET, 32'h0);
        chk("read-only write", 32'(resp), 32'h2);
        complete_run();
    end
endmodule
